/* File: common/eri_pkg.sv */
// Shared constants for the external request interrupt unit.
package eri_pkg;
	localparam int         NCH          = 8;
	localparam int         COND_W       = 2;
	localparam int         IDX_W        = 8;
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_ENABLE   = 8'h30;
	localparam logic [7:0] IDX_FLAGS    = 8'h31;
	localparam logic [7:0] IDX_COND     = 8'h32;
	localparam logic [7:0] IDX_MODE     = 8'h33;
	localparam logic [7:0] IDX_ISTAT    = 8'h34;
	localparam logic [7:0] IDX_ICLR     = 8'h35;
	localparam logic [7:0] IDX_IEN      = 8'h36;
	localparam int         ADDR_LSB     = 2;
	// Reset values.
	localparam logic [7:0]  RST_ENABLE  = 8'h00;
	localparam logic [7:0]  RST_FLAGS   = 8'h00;
	localparam logic [15:0] RST_COND    = 16'h000a;
	localparam logic [7:0]  RST_MODE    = 8'h00;
	localparam logic [7:0]  RST_ISTAT   = 8'h00;
	localparam logic [7:0]  RST_IEN     = 8'h00;
	// Detection condition codes per channel field.
	localparam logic [1:0]  COND_LOW    = 2'h0;
	localparam logic [1:0]  COND_HIGH   = 2'h1;
	localparam logic [1:0]  COND_RISE   = 2'h2;
	localparam logic [1:0]  COND_FALL   = 2'h3;
	// Channels 0 and 1 have the edge bit of their field forced high.
	localparam logic [15:0] COND_EDGE_FORCE = 16'h000a;
	// Channels able to start the transfer service or wake the core.
	localparam logic [7:0]  XFER_CAPABLE = 8'hfc;
	localparam int          HTRANS_ACTIVE_BIT = 1;
endpackage

/* File: common/eri_if.sv */
// Internal register access carrier between the bus slave and the register file.
`timescale 1ns/10ps
interface eri_if;
	logic        wr;
	logic [7:0]  widx;
	logic [31:0] wdata;
	logic        rd;
	logic [7:0]  ridx;
	logic [31:0] rdata;
	modport bus  (output wr, output widx, output wdata, output rd, output ridx, input rdata);
	modport regs (input wr, input widx, input wdata, input rd, input ridx, output rdata);
endinterface

/* File: logic/eri_detect.sv */
// Per-channel request detection on synchronised pin levels.
`timescale 1ns/10ps
module eri_detect #(
	parameter int N = 8
) (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic [N-1:0]   pin,
	input  wire logic [2*N-1:0] cond,
	output logic      [N-1:0]   evt
);
	logic [N-1:0] prev_reg;
	logic         prev_ok_reg;

	// Edges are gated until one real sample exists, so reset cannot fake an edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg    <= '0;
			prev_ok_reg <= 1'b0;
		end else begin
			prev_reg    <= pin;
			prev_ok_reg <= 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			wire logic [1:0] c    = cond[2*g +: 2];
			wire logic       rise = prev_ok_reg & pin[g] & ~prev_reg[g];
			wire logic       fall = prev_ok_reg & ~pin[g] & prev_reg[g];
			assign evt[g] = ((c == eri_pkg::COND_LOW) & ~pin[g])
				| ((c == eri_pkg::COND_HIGH) & pin[g])
				| ((c == eri_pkg::COND_RISE) & rise)
				| ((c == eri_pkg::COND_FALL) & fall);
		end
	endgenerate
endmodule

/* File: logic/eri_ahb_slave.sv */
// AHB-Lite slave front end with zero wait states.
`timescale 1ns/10ps
module eri_ahb_slave (
	input  wire logic        hclk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	eri_if.bus               rb
);
	logic       wr_pend_reg;
	logic [7:0] widx_reg;

	wire logic ap_valid = hsel & htrans[eri_pkg::HTRANS_ACTIVE_BIT] & hready;

	// Only whole words are supported, so hsize is accepted but not decoded.
	assign rb.wr    = wr_pend_reg;
	assign rb.widx  = widx_reg;
	assign rb.wdata = hwdata;
	assign rb.rd    = ap_valid & ~hwrite;
	assign rb.ridx  = haddr[eri_pkg::ADDR_LSB +: eri_pkg::IDX_W];

	always_ff @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_reg <= 1'b0;
			widx_reg    <= 8'h00;
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else begin
			wr_pend_reg <= ap_valid & hwrite;
			widx_reg    <= haddr[eri_pkg::ADDR_LSB +: eri_pkg::IDX_W];
			hrdata      <= rb.rd ? rb.rdata : 32'h0000_0000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end
	end
endmodule

/* File: logic/eri_top.sv */
// Eight-channel external request interrupt unit with AHB-Lite registers.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
module eri_top (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  req_pin,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	output logic      [7:0]  irq_req_reg,
	output logic      [7:0]  xfer_req_reg,
	output logic             wake_req_reg,
	output logic             irq_reg
);
	localparam int N = eri_pkg::NCH;

	logic         rst_meta_reg;
	logic         rst_n;
	logic [N-1:0] pin_meta_reg;
	logic [N-1:0] pin_sync_reg;

	logic [7:0]   enable_reg;
	logic [7:0]   enable_next;
	logic [7:0]   flags_reg;
	logic [7:0]   flags_next;
	logic [15:0]  cond_reg;
	logic [15:0]  cond_next;
	logic [7:0]   mode_reg;
	logic [7:0]   mode_next;
	logic [7:0]   istat_reg;
	logic [7:0]   istat_next;
	logic [7:0]   ien_reg;
	logic [7:0]   ien_next;
	logic [N-1:0] evt;

	eri_if rb ();

	// The reset is released through two flops so all flops reset by rst_n leave reset together.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// Request pins are asynchronous; only the second flop is used by logic.
	// No reset here, so the synchroniser holds the real pin levels when reset ends.
	// A reset value would fake a level request or an edge on an idle pin.
	always_ff @(posedge sys_clk) begin
		pin_meta_reg <= req_pin;
		pin_sync_reg <= pin_meta_reg;
	end

	eri_ahb_slave u_slave (
		.hclk      (sys_clk),
		.rst_n     (rst_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.rb        (rb.bus)
	);

	eri_detect #(.N(N)) u_detect (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.pin   (pin_sync_reg),
		.cond  (cond_reg),
		.evt   (evt)
	);

	wire logic wr_enable = rb.wr & (rb.widx == eri_pkg::IDX_ENABLE);
	wire logic wr_flags  = rb.wr & (rb.widx == eri_pkg::IDX_FLAGS);
	wire logic wr_cond   = rb.wr & (rb.widx == eri_pkg::IDX_COND);
	wire logic wr_mode   = rb.wr & (rb.widx == eri_pkg::IDX_MODE);
	wire logic wr_iclr   = rb.wr & (rb.widx == eri_pkg::IDX_ICLR);
	wire logic wr_ien    = rb.wr & (rb.widx == eri_pkg::IDX_IEN);

	wire logic rd_enable = rb.ridx == eri_pkg::IDX_ENABLE;
	wire logic rd_flags  = rb.ridx == eri_pkg::IDX_FLAGS;
	wire logic rd_cond   = rb.ridx == eri_pkg::IDX_COND;
	wire logic rd_mode   = rb.ridx == eri_pkg::IDX_MODE;
	wire logic rd_istat  = rb.ridx == eri_pkg::IDX_ISTAT;
	wire logic rd_ien    = rb.ridx == eri_pkg::IDX_IEN;

	// The clear register is write-only and unmapped indices read as zero.
	assign rb.rdata = rd_enable ? {24'h00_0000, enable_reg}
		: rd_flags ? {24'h00_0000, flags_reg}
		: rd_cond ? {16'h0000, cond_reg}
		: rd_mode ? {24'h00_0000, mode_reg}
		: rd_istat ? {24'h00_0000, istat_reg}
		: rd_ien ? {24'h00_0000, ien_reg}
		: 32'h0000_0000;

	assign enable_next = wr_enable ? rb.wdata[7:0] : enable_reg;

	assign flags_next = (flags_reg & (wr_flags ? rb.wdata[7:0] : 8'hff)) | evt;

	// edge only on 0 and 1
	assign cond_next = wr_cond ? (rb.wdata[15:0] | eri_pkg::COND_EDGE_FORCE) : cond_reg;

	// no transfer on 0 and 1
	assign mode_next = wr_mode ? (rb.wdata[7:0] & eri_pkg::XFER_CAPABLE) : mode_reg;

	assign istat_next = (istat_reg & ~(wr_iclr ? rb.wdata[7:0] : 8'h00)) | evt;
	assign ien_next   = wr_ien ? rb.wdata[7:0] : ien_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= eri_pkg::RST_ENABLE;
			flags_reg  <= eri_pkg::RST_FLAGS;
			cond_reg   <= eri_pkg::RST_COND;
			mode_reg   <= eri_pkg::RST_MODE;
			istat_reg  <= eri_pkg::RST_ISTAT;
			ien_reg    <= eri_pkg::RST_IEN;
		end else begin
			enable_reg <= enable_next;
			flags_reg  <= flags_next;
			cond_reg   <= cond_next;
			mode_reg   <= mode_next;
			istat_reg  <= istat_next;
			ien_reg    <= ien_next;
		end
	end

	wire logic [7:0] active = flags_reg & enable_reg;

	// Outputs are registered, which costs one cycle of latency but keeps them glitch free.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_req_reg  <= 8'h00;
			xfer_req_reg <= 8'h00;
			wake_req_reg <= 1'b0;
			irq_reg      <= 1'b0;
		end else begin
			irq_req_reg  <= active & ~mode_reg;
			// level transfer on 2 to 7
			xfer_req_reg <= active & mode_reg & eri_pkg::XFER_CAPABLE;
			wake_req_reg <= |(active & eri_pkg::XFER_CAPABLE);
			irq_reg      <= |(istat_reg & ien_reg);
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	property p_route_exclusive;
		(irq_req_reg & xfer_req_reg) == 8'h00;
	endproperty
	a_route_exclusive: assert property (p_route_exclusive)
		else $error("Channel routed to interrupt and transfer at once.");

	property p_level_high_ch2;
		(cond_reg[5:4] == eri_pkg::COND_HIGH && pin_sync_reg[2]) |=> flags_reg[2];
	endproperty
	a_level_high_ch2: assert property (p_level_high_ch2)
		else $error("High level on channel 2 did not raise its flag.");

	property p_rise_ch3;
		(cond_reg[7:6] == eri_pkg::COND_RISE && pin_sync_reg[3] && !$past(pin_sync_reg[3])
			&& $past(rst_n)) |=> flags_reg[3];
	endproperty
	a_rise_ch3: assert property (p_rise_ch3)
		else $error("Rising edge on channel 3 did not raise its flag.");

	property p_edge_only_low;
		cond_reg[1] && cond_reg[3];
	endproperty
	a_edge_only_low: assert property (p_edge_only_low)
		else $error("Channel 0 or 1 set to level detection.");

	property p_no_xfer_low;
		((active & eri_pkg::XFER_CAPABLE) == 8'h00) |=> (!wake_req_reg && xfer_req_reg[1:0] == 2'h0);
	endproperty
	a_no_xfer_low: assert property (p_no_xfer_low)
		else $error("Channel 0 or 1 caused transfer or wake.");

	property p_flag_clear;
		(wr_flags && !rb.wdata[4] && !evt[4]) ##1 !evt[4] |-> !flags_reg[4];
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("Flag 4 not cleared by software write.");

	property p_set_wins;
		evt[5] |=> flags_reg[5] && istat_reg[5];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("Detection event lost against a clear.");

	property p_enable_write;
		wr_enable |=> enable_reg == $past(rb.wdata[7:0]);
	endproperty
	a_enable_write: assert property (p_enable_write)
		else $error("Enable register did not take written value.");

	property p_cond_write;
		wr_cond |=> cond_reg == ($past(rb.wdata[15:0]) | eri_pkg::COND_EDGE_FORCE);
	endproperty
	a_cond_write: assert property (p_cond_write)
		else $error("Condition register did not take written value.");

	property p_gate;
		(active == 8'h00) [*2] |-> (irq_req_reg == 8'h00 && xfer_req_reg == 8'h00);
	endproperty
	a_gate: assert property (p_gate)
		else $error("Request to core without flag and enable.");

	property p_irq_out;
		((istat_reg & ien_reg) != 8'h00) |=> irq_reg;
	endproperty
	a_irq_out: assert property (p_irq_out)
		else $error("Status interrupt output missing.");

	property p_irq_off;
		((istat_reg & ien_reg) == 8'h00) |=> !irq_reg;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("Status interrupt output without an enabled status bit.");

	property p_irq_route;
		(active[6] && !mode_reg[6]) |=> irq_req_reg[6];
	endproperty
	a_irq_route: assert property (p_irq_route)
		else $error("Channel 6 interrupt request missing.");

	property p_xfer_level_ch7;
		(cond_reg[15:14] == eri_pkg::COND_LOW && !pin_sync_reg[7])
			##1 (enable_reg[7] && mode_reg[7]) |=> xfer_req_reg[7];
	endproperty
	a_xfer_level_ch7: assert property (p_xfer_level_ch7)
		else $error("Low level on channel 7 did not raise a transfer request.");

	property p_fall_ch6;
		(cond_reg[13:12] == eri_pkg::COND_FALL && !pin_sync_reg[6] && $past(pin_sync_reg[6])
			&& $past(rst_n)) |=> flags_reg[6];
	endproperty
	a_fall_ch6: assert property (p_fall_ch6)
		else $error("Falling edge on channel 6 did not raise its flag.");

	property p_mode_low_zero;
		mode_reg[1:0] == 2'h0;
	endproperty
	a_mode_low_zero: assert property (p_mode_low_zero)
		else $error("Channel 0 or 1 routed to the transfer service.");

	property p_wake_ch2;
		(flags_reg[2] && enable_reg[2]) |=> wake_req_reg;
	endproperty
	a_wake_ch2: assert property (p_wake_ch2)
		else $error("Channel 2 request did not raise the wake request.");

	property p_flag_write_no_set;
		(wr_flags && rb.wdata[0] && !flags_reg[0] && !evt[0]) |=> !flags_reg[0];
	endproperty
	a_flag_write_no_set: assert property (p_flag_write_no_set)
		else $error("Software write of one set flag 0.");

	property p_enable_hold;
		!wr_enable |=> $stable(enable_reg);
	endproperty
	a_enable_hold: assert property (p_enable_hold)
		else $error("Enable register changed without a write.");

	property p_cond_hold;
		!wr_cond |=> $stable(cond_reg);
	endproperty
	a_cond_hold: assert property (p_cond_hold)
		else $error("Condition register changed without a write.");

	c_irq_path: cover property (evt[2] ##[1:4] irq_req_reg[2]);
	c_level_xfer: cover property (xfer_req_reg[7] && cond_reg[15:14] == eri_pkg::COND_LOW);
	c_xfer_path: cover property (evt[6] ##[1:4] xfer_req_reg[6]);
	c_clear_race: cover property (wr_flags && evt != 8'h00);
	c_status_irq: cover property (irq_reg ##[1:20] !irq_reg);
endmodule

/* File: tb/eri_periph.sv */
// Model of the outside circuits that raise levels on the request pins.
`timescale 1ns/10ps
module eri_periph (
	input  wire logic       clk,
	input  wire logic       slow,
	input  wire logic [7:0] lvl,
	output logic      [7:0] req_pin
);
	logic [7:0] d1_reg;
	logic [7:0] d2_reg;
	always_ff @(posedge clk) begin
		d1_reg <= lvl;
		d2_reg <= d1_reg;
	end
	// Slow mode lags the requested levels by two cycles to vary detection timing.
	assign req_pin = slow ? d2_reg : lvl;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the external request interrupt unit.
`timescale 1ns/10ps
module testbench;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  req_pin;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire logic   hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [7:0]  irq_req_reg;
	logic [7:0]  xfer_req_reg;
	logic        wake_req_reg;
	logic        irq_reg;
	logic        slow = 1'b0;
	logic [7:0]  lvl = 8'hfc;
	logic        rd_dp = 1'b0;
	logic [63:0] notes[$];
	logic [7:0]  flg = 8'h0;
	logic [7:0]  en = 8'h0;
	logic [7:0]  md = 8'h0;
	logic [7:0]  ist = 8'h0;
	logic [7:0]  ien = 8'h0;
	int          fails = 0;
	int          total_checks = 0;
	assign hready = hreadyout;
	always #2 sys_clk = ~sys_clk;
	eri_top eri_top_i (.sys_clk(sys_clk), .resetn(resetn), .req_pin(req_pin), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.irq_req_reg(irq_req_reg), .xfer_req_reg(xfer_req_reg),
		.wake_req_reg(wake_req_reg), .irq_reg(irq_reg));
	eri_periph eri_periph_i (.clk(sys_clk), .slow(slow), .lvl(lvl), .req_pin(req_pin));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hready !== 1'b1);
	endtask
	// The note carries the expected core-side outputs next to the read data.
	task automatic rd(input logic [7:0] idx, input logic [31:0] d);
		logic [7:0] a;
		a = flg & en;
		notes.push_back({14'h0, |(ist & ien), |(a & 8'hfc), a & md, a & ~md, d});
		bus(1'b0, idx, 32'h0);
	endtask
	always @(posedge sys_clk) begin
		if (rd_dp && hready === 1'b1) begin
			// Read data and request outputs.
			check({13'h0, hresp, irq_reg, wake_req_reg, xfer_req_reg, irq_req_reg, hrdata},
				notes.pop_front());
		end
		if (hready === 1'b1) begin
			rd_dp <= hsel && htrans[1] && !hwrite;
		end
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		end_of_test();
	end
	initial begin
		logic [1:0]  e;
		logic        inact;
		logic [15:0] cnd;
		void'($urandom(71422));
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		// Reset values and refused writes.
		bus(1'b1, eri_pkg::IDX_ISTAT, 32'hff);
		bus(1'b1, 8'h3f, 32'hffffffff);
		bus(1'b1, eri_pkg::IDX_FLAGS, 32'hff);
		rd(eri_pkg::IDX_ENABLE, 32'h0);
		rd(eri_pkg::IDX_FLAGS, 32'h0);
		rd(eri_pkg::IDX_COND, 32'h0000000a);
		rd(eri_pkg::IDX_MODE, 32'h0);
		rd(eri_pkg::IDX_ISTAT, 32'h0);
		rd(eri_pkg::IDX_IEN, 32'h0);
		rd(8'h3f, 32'h0);
		$display("test reset_values done");
		for (int ch = 0; ch < 8; ch++) begin
			for (int c = 0; c < 4; c++) begin
				// channels 0 and 1 edge only
				e = (ch < 2) ? (2'(c) | 2'h2) : 2'(c);
				inact = (e == eri_pkg::COND_LOW) || (e == eri_pkg::COND_FALL);
				cnd = (16'haaaa & ~(16'h3 << (2 * ch))) | (16'(e) << (2 * ch));
				lvl <= inact ? (8'h1 << ch) : 8'h0;
				slow <= 1'($urandom);
				en = 8'($urandom);
				md = 8'($urandom);
				ien = 8'($urandom);
				bus(1'b1, eri_pkg::IDX_COND, {16'h0, cnd});
				bus(1'b1, eri_pkg::IDX_ENABLE, {24'h0, en});
				bus(1'b1, eri_pkg::IDX_MODE, {24'h0, md});
				md = md & 8'hfc;
				bus(1'b1, eri_pkg::IDX_IEN, {24'h0, ien});
				repeat (8) @(posedge sys_clk);
				bus(1'b1, eri_pkg::IDX_FLAGS, 32'h0);
				bus(1'b1, eri_pkg::IDX_ICLR, 32'hff);
				flg = 8'h0;
				ist = 8'h0;
				rd(eri_pkg::IDX_COND, {16'h0, cnd | 16'h000a});
				rd(eri_pkg::IDX_ENABLE, {24'h0, en});
				rd(eri_pkg::IDX_MODE, {24'h0, md});
				lvl <= lvl ^ (8'h1 << ch);
				repeat (12) @(posedge sys_clk);
				flg = 8'h1 << ch;
				ist = flg;
				rd(eri_pkg::IDX_FLAGS, {24'h0, flg});
				rd(eri_pkg::IDX_ISTAT, {24'h0, ist});
				bus(1'b1, eri_pkg::IDX_FLAGS, 32'h0);
				// A held level keeps its flag set; an edge flag stays cleared.
				flg = e[1] ? 8'h0 : flg;
				rd(eri_pkg::IDX_FLAGS, {24'h0, flg});
				lvl <= lvl ^ (8'h1 << ch);
				@(posedge sys_clk);
			end
		end
		$display("test detection done");
		end_of_test();
	end
endmodule
